/* verilog/spg_pkg.sv */
package spg_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_VSTART = 8'h08;
   localparam logic [7:0] REG_VPROG = 8'h0c;
   localparam logic [7:0] REG_ACCEL = 8'h10;
   localparam logic [7:0] REG_DECEL = 8'h14;
   localparam logic [7:0] REG_JERK = 8'h18;
   localparam logic [7:0] REG_LEN = 8'h1c;
   localparam logic [7:0] REG_POS = 8'h20;
   localparam logic [7:0] REG_RATE = 8'h24;

   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;

   localparam logic [23:0] VSTART_RST = 24'h000001;
   localparam logic [23:0] VPROG_RST = 24'h0003e8;
   localparam logic [15:0] ACCEL_RST = 16'h0001;
   localparam logic [15:0] DECEL_RST = 16'h0001;
   localparam logic [15:0] JERK_RST = 16'h0000;
   localparam logic [31:0] LEN_RST = 32'h00000000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RATE_TICK_NS = 1_000_000;
   localparam int RATE_TICK_CYC = RATE_TICK_NS / CLK_PERIOD_NS;
   // rate parameters are per millisecond: one unit is 1000 per second squared
   localparam int MS_PER_S = 1000;
   localparam logic [15:0] JERK_MIN = 16'h0001;
   localparam logic [15:0] JERK_MAX = 16'h1388;
   // 2^32 / 100000, turns jerk*accel into a 16.16 accel step per tick
   localparam logic [15:0] JERK_SCALE = 16'ha7c6;

   typedef struct packed {
      logic [23:0] v_start;
      logic [23:0] v_prog;
      logic [15:0] accel;
      logic [15:0] decel;
      logic [15:0] jerk;
      logic [31:0] len;
   } spg_cfg_t;

   typedef enum logic [3:0] {
      SPG_IDLE = 4'b0001,
      SPG_ACC = 4'b0010,
      SPG_CRUISE = 4'b0100,
      SPG_DEC = 4'b1000
   } spg_state_t;

endpackage : spg_pkg

/* verilog/spg_top.sv */
`timescale 1ns/1ps
module spg_top #(
   parameter int CLK_FREQ = spg_pkg::CLK_HZ,
   parameter int TICK_CYC = spg_pkg::RATE_TICK_CYC
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic step_out
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_s1_q, rst_b_q;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_b_q <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // apb slave, one wait state
   // ----------------------------------------------------------------
   logic pready_q, pslverr_q, step_q, done_q;
   logic [31:0] prdata_q, rd_data, rem_q, pos_q, phase_q;
   logic [31:0] tick_q;
   logic [39:0] v_fx_q;
   logic [31:0] a_fx_q;
   logic hit, acc_ph, xfer, wr, go, abort;
   spg_pkg::spg_cfg_t cfg_q, run_q;
   spg_pkg::spg_state_t state_q;

   assign acc_ph = psel_in & penable_in & ~pready_q;
   assign xfer = psel_in & penable_in & pready_q;
   assign wr = xfer & pwrite_in;
   assign go = wr & (paddr_in == spg_pkg::REG_CTRL)
      & pwdata_in[spg_pkg::CTRL_GO_BIT] & state_q[0];
   assign abort = wr & (paddr_in == spg_pkg::REG_CTRL)
      & pwdata_in[spg_pkg::CTRL_ABORT_BIT];

   always_comb begin
      hit = 1'b1;
      rd_data = 32'h00000000;
      unique case (paddr_in)
         spg_pkg::REG_CTRL: rd_data = 32'h00000000;
         spg_pkg::REG_STATUS: begin
            rd_data[spg_pkg::STAT_BUSY_BIT] = ~state_q[0];
            rd_data[spg_pkg::STAT_DONE_BIT] = done_q;
         end
         spg_pkg::REG_VSTART: rd_data = {8'h00, cfg_q.v_start};
         spg_pkg::REG_VPROG: rd_data = {8'h00, cfg_q.v_prog};
         spg_pkg::REG_ACCEL: rd_data = {16'h0000, cfg_q.accel};
         spg_pkg::REG_DECEL: rd_data = {16'h0000, cfg_q.decel};
         spg_pkg::REG_JERK: rd_data = {16'h0000, cfg_q.jerk};
         spg_pkg::REG_LEN: rd_data = cfg_q.len;
         spg_pkg::REG_POS: rd_data = pos_q;
         spg_pkg::REG_RATE: rd_data = {8'h00, v_fx_q[39:16]};
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_q) begin
      if (!rst_b_q) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else if (ce_in) begin
         pready_q <= acc_ph;
         if (acc_ph) begin
            pslverr_q <= ~hit;
            prdata_q <= pwrite_in ? 32'h00000000 : rd_data;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_q) begin
      if (!rst_b_q) begin
         cfg_q <= '{spg_pkg::VSTART_RST, spg_pkg::VPROG_RST,
            spg_pkg::ACCEL_RST, spg_pkg::DECEL_RST,
            spg_pkg::JERK_RST, spg_pkg::LEN_RST};
      end else if (ce_in && wr) begin
         unique case (paddr_in)
            spg_pkg::REG_VSTART: cfg_q.v_start <= pwdata_in[23:0];
            spg_pkg::REG_VPROG: cfg_q.v_prog <= pwdata_in[23:0];
            spg_pkg::REG_ACCEL: cfg_q.accel <= pwdata_in[15:0];
            spg_pkg::REG_DECEL: cfg_q.decel <= pwdata_in[15:0];
            spg_pkg::REG_JERK: cfg_q.jerk <= pwdata_in[15:0];
            spg_pkg::REG_LEN: cfg_q.len <= pwdata_in;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // profile arithmetic
   // ----------------------------------------------------------------
   // a zero start speed would never step, so it runs as 1
   logic [23:0] vs, v_int;
   logic [39:0] vs_fx, vp_fx, v_up, v_dn, d_fx;
   logic [31:0] a_full, a_use, a_sum;
   logic [47:0] a_inc_w;
   logic [63:0] need_l, need_r;
   logic smooth, need_dec, tick, step_now, last, run;
   logic [32:0] ph_sum;

   assign vs = (run_q.v_start == 24'h000000) ? 24'h000001
      : run_q.v_start;
   assign v_int = v_fx_q[39:16];
   assign vs_fx = {vs, 16'h0000};
   assign vp_fx = {run_q.v_prog, 16'h0000};
   assign d_fx = {8'h00, run_q.decel, 16'h0000};
   assign a_full = {run_q.accel, 16'h0000};
   assign smooth = (run_q.jerk >= spg_pkg::JERK_MIN)
      && (run_q.jerk <= spg_pkg::JERK_MAX);
   assign a_inc_w = 48'(run_q.jerk) * 48'(run_q.accel)
      * 48'(spg_pkg::JERK_SCALE);
   assign a_sum = a_fx_q + a_inc_w[47:16];
   assign a_use = smooth ? a_fx_q : a_full;
   assign v_up = ((v_fx_q + 40'(a_use)) >= vp_fx) ? vp_fx
      : v_fx_q + 40'(a_use);
   assign v_dn = (v_fx_q < vs_fx + d_fx) ? vs_fx : v_fx_q - d_fx;
   // decel distance (v^2-vs^2)/2d, d in steps/s^2 = param*1000
   assign need_l = 64'(rem_q) * 64'(run_q.decel)
      * 64'(2 * spg_pkg::MS_PER_S);
   assign need_r = 64'(v_int) * 64'(v_int) - 64'(vs) * 64'(vs);
   assign need_dec = need_l <= need_r;
   assign run = ~state_q[0];
   assign tick = tick_q == 32'(TICK_CYC - 1);
   assign ph_sum = {1'b0, phase_q} + 33'(v_int);
   assign step_now = run && (ph_sum >= 33'(CLK_FREQ));
   assign last = step_now && (rem_q == 32'h00000001);

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_q) begin
      if (!rst_b_q) begin
         state_q <= spg_pkg::SPG_IDLE;
      end else if (ce_in) begin
         unique case (state_q)
            spg_pkg::SPG_IDLE: begin
               if (go && cfg_q.len != 32'h00000000) begin
                  state_q <= spg_pkg::SPG_ACC;
               end
            end
            spg_pkg::SPG_ACC: begin
               if (need_dec) begin
                  state_q <= spg_pkg::SPG_DEC;
               end else if (v_fx_q == vp_fx) begin
                  state_q <= spg_pkg::SPG_CRUISE;
               end
            end
            spg_pkg::SPG_CRUISE: begin
               // cruise until only the decel steps remain
               if (need_dec) begin
                  state_q <= spg_pkg::SPG_DEC;
               end
            end
            spg_pkg::SPG_DEC: ;
         endcase
         if (run && (abort || last)) begin
            state_q <= spg_pkg::SPG_IDLE;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_q) begin
      if (!rst_b_q) begin
         run_q <= '0;
      end else if (ce_in && go) begin
         run_q <= cfg_q;
      end
   end

   // ----------------------------------------------------------------
   // speed and acceleration, updated once per millisecond
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_q) begin
      if (!rst_b_q) begin
         v_fx_q <= 40'h0000000000;
         a_fx_q <= 32'h00000000;
         tick_q <= 32'h00000000;
      end else if (ce_in) begin
         if (go) begin
            v_fx_q <= {((cfg_q.v_start == 24'h000000) ? 24'h000001
               : cfg_q.v_start), 16'h0000};
            a_fx_q <= 32'h00000000;
            tick_q <= 32'h00000000;
         end else if (run) begin
            tick_q <= tick ? 32'h00000000 : tick_q + 32'h00000001;
            if (tick && state_q == spg_pkg::SPG_ACC) begin
               v_fx_q <= v_up;
               // s-curve: accel grows by jerk each tick to the cap
               a_fx_q <= (a_sum >= a_full) ? a_full : a_sum;
            end
            if (state_q == spg_pkg::SPG_DEC) begin
               if (rem_q == 32'h00000001) begin
                  v_fx_q <= vs_fx;
               end else if (tick) begin
                  v_fx_q <= v_dn;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // step pulse generator
   // ----------------------------------------------------------------
   // phase accumulator: pulse spacing jitters by one clock at most
   always_ff @(posedge clk_in or negedge rst_b_q) begin
      if (!rst_b_q) begin
         phase_q <= 32'h00000000;
         step_q <= 1'b0;
         rem_q <= 32'h00000000;
         pos_q <= 32'h00000000;
         done_q <= 1'b0;
      end else if (ce_in) begin
         step_q <= step_now && !abort;
         if (go) begin
            phase_q <= 32'h00000000;
            rem_q <= cfg_q.len;
            pos_q <= 32'h00000000;
            done_q <= (cfg_q.len == 32'h00000000);
         end else if (run && !abort) begin
            phase_q <= step_now ? ph_sum[31:0] - 32'(CLK_FREQ)
               : ph_sum[31:0];
            if (step_now) begin
               rem_q <= rem_q - 32'h00000001;
               pos_q <= pos_q + 32'h00000001;
            end
            if (last) begin
               done_q <= 1'b1;
            end
         end
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign step_out = step_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // a zero-length go sets done but never leaves idle
   sequence s_start;
      go && ce_in && cfg_q.len != 32'h00000000;
   endsequence

   sequence s_final;
      last && ce_in && !abort;
   endsequence

   a_step_single: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      step_q && ce_in |=> !step_q)
      else $error("step pulse longer than one cycle");

   a_count_exact: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      s_final |=> state_q == spg_pkg::SPG_IDLE && pos_q == run_q.len
      && step_q)
      else $error("move did not end on its final count");

   a_start_speed: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      s_start |=> v_int == vs && state_q != spg_pkg::SPG_IDLE)
      else $error("move did not begin at starting speed");

   a_speed_cap: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      run |-> v_int <= run_q.v_prog || v_int == vs)
      else $error("speed above programmed speed");

   a_linear_ramp: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      ce_in && tick && state_q == spg_pkg::SPG_ACC && !smooth
      && !go && !abort |=> v_int == $past(v_int) + 24'(run_q.accel)
      || v_int == run_q.v_prog || state_q[0])
      else $error("ramp step is not the accel rate");

   a_cruise_hold: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      ce_in && state_q == spg_pkg::SPG_CRUISE && !abort && !last
      |=> $stable(v_fx_q))
      else $error("speed changed while cruising");

   a_no_reaccel: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      state_q == spg_pkg::SPG_DEC |=> state_q == spg_pkg::SPG_DEC
      || state_q == spg_pkg::SPG_IDLE)
      else $error("left deceleration other than by ending");

   a_decel_floor: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      state_q == spg_pkg::SPG_DEC |-> v_int >= vs)
      else $error("decel went below starting speed");

   a_final_slow: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      s_final and (state_q == spg_pkg::SPG_DEC) |-> v_int == vs)
      else $error("final step not at starting speed");

   a_enter_decel: assert property (
      @(posedge clk_in) disable iff (!rst_b_q)
      ce_in && need_dec && !last && !abort
      && (state_q == spg_pkg::SPG_CRUISE)
      |=> state_q == spg_pkg::SPG_DEC)
      else $error("decel not entered at its distance");

endmodule : spg_top

/* tb/spg_stage_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// power stage stand-in: counts pulses and times their spacing
// ----------------------------------------------------------------
module spg_stage_model (
   input wire logic clk_in,
   input wire logic clr_in,
   input wire logic step_in,
   output logic [31:0] cnt_out,
   output logic [31:0] end_out,
   output logic [31:0] min_out,
   output logic [31:0] last_out
);
   logic [31:0] now_q;
   logic step_d_q;
   logic rise;
   // a pulse stretched by a frozen clock enable is still one step
   assign rise = step_in && !step_d_q;
   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         cnt_out <= 32'h0;
         now_q <= 32'h0;
         end_out <= 32'h0;
         min_out <= 32'hffffffff;
         last_out <= 32'h0;
         step_d_q <= 1'b0;
      end else begin
         now_q <= now_q + 32'h1;
         step_d_q <= step_in;
         if (rise) begin
            cnt_out <= cnt_out + 32'h1;
            end_out <= now_q;
            last_out <= now_q - end_out;
            // first gap is from go, not between pulses
            if (cnt_out != 32'h0 && now_q - end_out < min_out) begin
               min_out <= now_q - end_out;
            end
         end
      end
   end
endmodule : spg_stage_model

/* tb/spg_top_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module spg_top_tb;
   // shortened counts: 1 s is FREQ cycles, 1 ms is TICK cycles
   localparam int FREQ = 100000;
   localparam int TICK = 100;
   localparam logic [31:0] VS = 32'h8d;
   localparam logic [31:0] VP = 32'h7d0;
   localparam logic [31:0] AC = 32'h14;
   typedef struct packed {logic [31:0] d; logic err; logic chk;} spg_exp_t;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic ce_in = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic clr = 1'b1;
   logic [7:0] pa = 8'h0;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, rd, cnt, tend, tmin, tlast;
   logic prdy, perr, step;
   spg_exp_t q[$];
   int errors = 0;
   int num_checks = 0;
   spg_top #(.CLK_FREQ(FREQ), .TICK_CYC(TICK)) u_spg_top (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
      .pready_out(prdy), .pslverr_out(perr), .step_out(step));
   spg_stage_model u_spg_stage_model (.clk_in(clk_in), .clr_in(clr),
      .step_in(step), .cnt_out(cnt), .end_out(tend), .min_out(tmin),
      .last_out(tlast));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   // ----------------------------------------------------------------
   // apb master and scoreboard
   // ----------------------------------------------------------------
   always @(posedge clk_in) begin
      if (psel && pen && prdy === 1'b1 && q.size() > 0) begin
         if (q[0].chk) `CHK(prd, q[0].d)
         `CHK(perr, q[0].err)
         void'(q.pop_front());
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic c,
      input logic er);
      int n;
      q.push_back('{e, er, c});
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (prdy !== 1'b1 && n < 100);
      rd = prd;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 100) begin
         errors++;
         wrap_up();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0, 1'b0);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, e, 1'b1, 1'b0);
   endtask : rdc
   task automatic rdn(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 32'h0, 1'b0, 1'b0);
   endtask : rdn
   task automatic cfg(input logic [31:0] j);
      wr(spg_pkg::REG_VSTART, VS);
      wr(spg_pkg::REG_VPROG, VP);
      wr(spg_pkg::REG_ACCEL, AC);
      wr(spg_pkg::REG_DECEL, AC);
      wr(spg_pkg::REG_JERK, j);
   endtask : cfg
   task automatic go(input logic [31:0] len);
      wr(spg_pkg::REG_LEN, len);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      wr(spg_pkg::REG_CTRL, 32'h1);
   endtask : go
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         rdn(spg_pkg::REG_STATUS);
         n++;
      end while (rd[spg_pkg::STAT_DONE_BIT] !== 1'b1 && n < 8500);
      if (n >= 8500) begin
         errors++;
         wrap_up();
      end
   endtask : wait_done
   // rate a little over five ticks into a move, then stop it
   task automatic early(input logic [31:0] j, input logic [31:0] lo,
      input logic [31:0] hi);
      logic [31:0] v;
      cfg(j);
      go(32'd199);
      repeat (540) @(posedge clk_in);
      rdn(spg_pkg::REG_RATE);
      `CHK(rd >= lo && rd <= hi, 1'b1)
      wr(spg_pkg::REG_CTRL, 32'h2);
      repeat (2) @(posedge clk_in);
      v = cnt;
      repeat (2000) @(posedge clk_in);
      `CHK(cnt, v)
      rdc(spg_pkg::REG_STATUS, 32'h0);
      $display("test jerk %0d done", j);
   endtask : early
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] v;
      v = $urandom(32'habd0ea8b);
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rdc(spg_pkg::REG_VSTART, 32'(spg_pkg::VSTART_RST));
      rdc(spg_pkg::REG_VPROG, 32'(spg_pkg::VPROG_RST));
      rdc(spg_pkg::REG_ACCEL, 32'(spg_pkg::ACCEL_RST));
      rdc(spg_pkg::REG_DECEL, 32'(spg_pkg::DECEL_RST));
      rdc(spg_pkg::REG_JERK, 32'(spg_pkg::JERK_RST));
      rdc(spg_pkg::REG_LEN, spg_pkg::LEN_RST);
      rdc(spg_pkg::REG_STATUS, 32'h0);
      apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1, 1'b1);
      v = $urandom();
      wr(spg_pkg::REG_JERK, v);
      rdc(spg_pkg::REG_JERK, v & 32'hffff);
      $display("test registers done");
      cfg(32'h0);
      go(32'h0);
      wait_done();
      `CHK(cnt, 32'h0)
      v = $urandom_range(30, 1);
      go(v);
      // clock enable dropped at random mid-move, no bus traffic then
      repeat (1500) begin
         @(posedge clk_in);
         ce_in <= ($urandom() % 4) != 0;
      end
      @(posedge clk_in);
      ce_in <= 1'b1;
      wait_done();
      `CHK(cnt, v)
      rdc(spg_pkg::REG_POS, v);
      $display("test random length done");
      go(32'd400);
      rdc(spg_pkg::REG_RATE, VS);
      repeat (540) @(posedge clk_in);
      rdn(spg_pkg::REG_RATE);
      `CHK(rd >= VS + 4 * AC && rd <= VS + 6 * AC, 1'b1)
      wr(spg_pkg::REG_CTRL, 32'h1);
      wait_done();
      `CHK(cnt, 32'd400)
      rdc(spg_pkg::REG_POS, 32'd400);
      rdc(spg_pkg::REG_STATUS, 32'h2);
      `CHK(tmin >= 49 && tmin <= 51, 1'b1)
      `CHK(tend >= 25800 && tend <= 31500, 1'b1)
      `CHK(tlast >= 250, 1'b1)
      $display("test trapezoid done");
      go(32'd100);
      wait_done();
      `CHK(cnt, 32'd100)
      `CHK(tmin >= 64 && tmin <= 78, 1'b1)
      `CHK(tend >= 11500 && tend <= 14100, 1'b1)
      $display("test short triangle done");
      go(32'd199);
      wait_done();
      `CHK(cnt, 32'd199)
      `CHK(tmin >= 49 && tmin <= 56, 1'b1)
      $display("test exact fit done");
      early(32'd50, VS, VS + 2 * AC);
      early(32'h1770, VS + 4 * AC, VS + 6 * AC);
      wrap_up();
   end
endmodule : spg_top_tb
